// >>> src/rsc_pkg.sv
// package for the reset and stop release controller
package rsc_pkg;
  // reset vector addresses
  localparam logic [15:0] RSC_VEC_LO_ADDR = 16'h0000;
  localparam logic [15:0] RSC_VEC_HI_ADDR = 16'h0001;
  // clock rate and timing
  localparam int RSC_CLK_MHZ        = 125;
  localparam int RSC_PIN_LOW_MIN_US = 10;
  localparam int RSC_PIN_LOW_MIN_CYC = RSC_PIN_LOW_MIN_US * RSC_CLK_MHZ;
  localparam int RSC_PROC_CYC_DEF   = 16;
  localparam int RSC_STAB_CYC_DEF   = 64;
  // register map (own choice)
  localparam logic [3:0] RSC_REG_CTRL   = 4'h0;
  localparam logic [3:0] RSC_REG_STATUS = 4'h4;
  localparam logic [3:0] RSC_REG_CAUSE  = 4'h8;
  localparam logic [3:0] RSC_REG_VECTOR = 4'hc;
  // field positions
  localparam int RSC_CTRL_IND_HI  = 0;
  localparam int RSC_CTRL_STOP    = 1;
  localparam logic [31:0] RSC_RD_UNMAPPED = 32'h0000_0000;
  // interrupt request qualifiers
  typedef struct packed {
    logic req;
    logic interrupt_mask_flag;
    logic priority_level_flag;
  } rsc_irq_t;
  // reset causes, sticky
  typedef struct packed {
    logic lvd;
    logic power_on_clear_detector;
    logic wdt;
    logic pin;
  } rsc_cause_t;
  typedef enum logic [4:0] {
    RSC_ST_RESET = 5'b00001,
    RSC_ST_PROC  = 5'b00010,
    RSC_ST_STAB  = 5'b00100,
    RSC_ST_RUN   = 5'b01000,
    RSC_ST_HALT  = 5'b10000
  } rsc_state_t;
endpackage : rsc_pkg

// >>> src/rsc_top.sv
// reset merge, release sequencing and halt-mode exit control
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - four sources merge into system reset
// - every reset restarts from vector 0000h/0001h
// - pins float, indicator low, during reset
// - pin reset ends on pin high
// - watchdog reset releases itself
// - detector reset ends when supply recovers
// - oscillator stopped while a source holds reset, clock inputs ignored
// - oscillator pins revert to port mode
// - cpu clock withheld during reset
// - halt contents kept, pins float on reset
// - low-voltage reset spares detector logic
// - watchdog reset also resets watchdog
// - power-on detector runs, low-voltage stopped unless it raised the reset
// - masked request keeps halt; ie decides service
// - low priority needs ie and isp
module rsc_top #(
  parameter int PROC_CYC = rsc_pkg::RSC_PROC_CYC_DEF,
  parameter int STAB_CYC = rsc_pkg::RSC_STAB_CYC_DEF
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_reset_pin_n,
  input  wire logic                i_wdt_overflow,
  input  wire logic                i_poc_low,
  input  wire logic                i_lvd_low,
  input  wire rsc_pkg::rsc_irq_t   i_irq,
  input  wire logic                i_global_interrupt_enable,
  input  wire logic                i_in_service_priority_flag,
  input  wire logic                i_halt_enter,
  input  wire logic [3:0]          i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  output logic [31:0]              o_avs_readdata,
  output logic                     o_avs_waitrequest,
  output logic                     o_sys_reset,
  output logic                     o_wdt_reset,
  output logic                     o_lvd_logic_reset,
  output logic                     o_lvd_enable,
  output logic                     o_poc_enable,
  output logic                     o_osc_enable,
  output logic                     o_ext_clk_valid,
  output logic                     o_osc_pins_port_mode,
  output logic                     o_cpu_clk_en,
  output logic                     o_cpu_sel_internal_high_speed_clock,
  output logic                     o_pins_hiz,
  output logic                     o_reset_indicator_pin_o,
  output logic                     o_reset_indicator_pin_oe,
  output logic                     o_halt_active,
  output logic                     o_irq_service,
  output logic                     o_fetch_start,
  output logic [15:0]              o_fetch_vector_addr
);
  import rsc_pkg::*;

  // ==========================================================
  // elaboration checks
  localparam int CNT_W   = 13;
  localparam int CNT_MAX = (1 << CNT_W) - 1;

  // refuse counts the phase counter cannot hold
  if (PROC_CYC < 1 || PROC_CYC > CNT_MAX) begin : g_bad_proc
    $error("rsc_top: PROC_CYC out of range");
  end
  if (STAB_CYC < 1 || STAB_CYC > CNT_MAX) begin : g_bad_stab
    $error("rsc_top: STAB_CYC out of range");
  end

  // ==========================================================
  // shared decode
  // register select, used by the write and read paths
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] reg_off);
    return addr == reg_off;
  endfunction : reg_hit

  // ==========================================================
  // input synchronisers
  logic [1:0] pin_s_q;
  logic [1:0] wdt_s_q;
  logic [1:0] poc_s_q;
  logic [1:0] lvd_s_q;

  // two flops per asynchronous source; pin turned active high
  always_ff @(posedge i_clk) begin
    pin_s_q <= {pin_s_q[0], ~i_reset_pin_n};
    wdt_s_q <= {wdt_s_q[0], i_wdt_overflow};
    poc_s_q <= {poc_s_q[0], i_poc_low};
    lvd_s_q <= {lvd_s_q[0], i_lvd_low};
  end

  logic       pin_rst;
  logic       wdt_rst;
  logic       poc_rst;
  logic       lvd_rst;
  logic       any_src;
  rsc_cause_t src_vec;

  // only the second flop is read downstream
  assign pin_rst = pin_s_q[1];
  assign wdt_rst = wdt_s_q[1];
  assign poc_rst = poc_s_q[1];
  assign lvd_rst = lvd_s_q[1] & o_lvd_enable;
  assign any_src = pin_rst | wdt_rst | poc_rst | lvd_rst;
  assign src_vec = {lvd_rst, poc_rst, wdt_rst, pin_rst};

  // ==========================================================
  // reset sequencer
  rsc_state_t       state_q;
  rsc_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic             cnt_done;
  logic             ind_hi_q;
  logic             stop_pending_q;
  rsc_cause_t       cause_q;
  logic             wake;
  logic             service;
  logic             rd_valid_q;

  // phase counter has run out
  assign cnt_done = (cnt_q == '0);

  // halt-mode release decision
  always_comb begin
    wake    = i_irq.req & ~i_irq.interrupt_mask_flag;
    service = 1'b0;
    if (wake) begin
      if (!i_irq.priority_level_flag) begin
        service = i_global_interrupt_enable;
      end else begin
        service = i_global_interrupt_enable & i_in_service_priority_flag;
      end
    end
  end

  // next state; any active source forces reset, halt included
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RSC_ST_RESET: begin
        if (!any_src) begin
          state_d = RSC_ST_PROC;
        end
      end
      RSC_ST_PROC: begin
        if (cnt_done) begin
          state_d = RSC_ST_STAB;
        end
      end
      RSC_ST_STAB: begin
        if (cnt_done) begin
          state_d = RSC_ST_RUN;
        end
      end
      RSC_ST_RUN: begin
        if (i_halt_enter || stop_pending_q) begin
          state_d = RSC_ST_HALT;
        end
      end
      RSC_ST_HALT: begin
        if (wake) begin
          state_d = RSC_ST_RUN;
        end
      end
    endcase
    if (any_src) begin
      state_d = RSC_ST_RESET;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= RSC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // phase counter: processing, then stabilisation wait
  always_ff @(posedge i_clk) begin
    if (i_rst || state_d == RSC_ST_RESET) begin
      cnt_q <= CNT_W'(PROC_CYC - 1);
    end else if (state_q == RSC_ST_PROC && cnt_done) begin
      cnt_q <= CNT_W'(STAB_CYC - 1);
    end else if (!cnt_done) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // sticky reset cause; a new cause wins over the clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cause_q <= '0;
    end else if (i_avs_write && !o_avs_waitrequest && reg_hit(i_avs_address, RSC_REG_CAUSE)) begin
      cause_q <= (cause_q & ~rsc_cause_t'(i_avs_writedata[3:0])) | src_vec;
    end else begin
      cause_q <= cause_q | src_vec;
    end
  end

  // indicator preset, dropped by every reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ind_hi_q <= 1'b0;
    end else if (state_q == RSC_ST_RESET) begin
      ind_hi_q <= 1'b0;
    end else if (i_avs_write && !o_avs_waitrequest && reg_hit(i_avs_address, RSC_REG_CTRL)) begin
      ind_hi_q <= i_avs_writedata[RSC_CTRL_IND_HI];
    end
  end

  // stop request, only meaningful while running
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stop_pending_q <= 1'b0;
    end else if (state_q != RSC_ST_RUN) begin
      stop_pending_q <= 1'b0;
    end else if (i_avs_write && !o_avs_waitrequest && reg_hit(i_avs_address, RSC_REG_CTRL)) begin
      stop_pending_q <= i_avs_writedata[RSC_CTRL_STOP];
    end
  end

  // service pulse on halt exit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_service <= 1'b0;
    end else begin
      o_irq_service <= (state_q == RSC_ST_HALT) && wake && !any_src && service;
    end
  end

  // fetch strobe at the end of the stabilisation wait
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fetch_start <= 1'b0;
    end else begin
      o_fetch_start <= (state_q == RSC_ST_STAB) && cnt_done && !any_src;
    end
  end

  // vector pointer is fixed; high byte sits at RSC_VEC_HI_ADDR
  assign o_fetch_vector_addr = RSC_VEC_LO_ADDR;

  // ==========================================================
  // reset period outputs
  logic in_reset;
  logic in_wait;

  // reset and processing, then the stabilisation wait
  assign in_reset = (state_q == RSC_ST_RESET) || (state_q == RSC_ST_PROC);
  assign in_wait  = in_reset || (state_q == RSC_ST_STAB);

  // sequencing and detector controls
  assign o_sys_reset          = in_reset;
  assign o_wdt_reset          = in_reset;
  assign o_lvd_logic_reset    = in_reset & ~cause_q.lvd & ~lvd_rst;
  assign o_lvd_enable         = (state_q != RSC_ST_RESET) || lvd_s_q[1];
  assign o_poc_enable         = 1'b1;

  // clock controls
  assign o_osc_enable         = (state_q != RSC_ST_RESET) && (state_q != RSC_ST_HALT);
  assign o_ext_clk_valid      = !in_reset;
  assign o_osc_pins_port_mode = in_reset;
  assign o_cpu_clk_en         = (state_q == RSC_ST_RUN);
  assign o_cpu_sel_internal_high_speed_clock = 1'b1;

  // pin controls
  assign o_pins_hiz           = in_wait;
  assign o_reset_indicator_pin_oe = in_wait | ind_hi_q;
  assign o_reset_indicator_pin_o  = ~in_wait & ind_hi_q;
  assign o_halt_active        = (state_q == RSC_ST_HALT);

  // ==========================================================
  // avalon slave: one wait state on reads, none on writes
  assign o_avs_waitrequest = i_avs_read & ~rd_valid_q;

  // read wait-state flop; data stand when waitrequest drops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= i_avs_read & ~rd_valid_q;
    end
  end

  // read data, loaded in the first cycle of a read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= RSC_RD_UNMAPPED;
    end else if (i_avs_read && !rd_valid_q) begin
      if (reg_hit(i_avs_address, RSC_REG_CTRL)) begin
        o_avs_readdata <= {30'h0, stop_pending_q, ind_hi_q};
      end else if (reg_hit(i_avs_address, RSC_REG_STATUS)) begin
        o_avs_readdata <= {27'h0, state_q};
      end else if (reg_hit(i_avs_address, RSC_REG_CAUSE)) begin
        o_avs_readdata <= {28'h0, cause_q};
      end else if (reg_hit(i_avs_address, RSC_REG_VECTOR)) begin
        o_avs_readdata <= {16'h0, RSC_VEC_LO_ADDR};
      end else begin
        o_avs_readdata <= RSC_RD_UNMAPPED;
      end
    end
  end
endmodule : rsc_top
`default_nettype wire

// >>> dv/rsc_src.sv
// reset source model: pin driver, watchdog and supply detectors
`timescale 1ns/1ps
`default_nettype none
// ==========
// source model
module rsc_src import rsc_pkg::*; (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [1:0] i_kind,
  output logic [3:0]      o_src
);
  int n = 0;
  // one source held active, then released
  always @(posedge i_clk) begin
    if (i_go && n == 0) n <= (i_kind == 2'h0) ? RSC_PIN_LOW_MIN_CYC : 8;
    else if (n > 0) n <= n - 1;
  end
  assign o_src = (n > 0) ? (4'h1 << i_kind) : 4'h0;
endmodule : rsc_src
`default_nettype wire

// >>> dv/rsc_sva.sv
// assertions on the reset controller ports
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module rsc_sva import rsc_pkg::*; (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_reset_pin_n,
  input wire logic        i_wdt_overflow,
  input wire logic        i_poc_low,
  input wire logic        i_lvd_low,
  input wire rsc_irq_t    i_irq,
  input wire logic        i_global_interrupt_enable,
  input wire logic        i_in_service_priority_flag,
  input wire logic        o_sys_reset,
  input wire logic        o_wdt_reset,
  input wire logic        o_osc_enable,
  input wire logic        o_cpu_clk_en,
  input wire logic        o_pins_hiz,
  input wire logic        o_reset_indicator_pin_o,
  input wire logic        o_reset_indicator_pin_oe,
  input wire logic        o_halt_active,
  input wire logic        o_irq_service,
  input wire logic        o_fetch_start,
  input wire logic [15:0] o_fetch_vector_addr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_rst_pins: assert property (o_sys_reset |-> o_pins_hiz && o_reset_indicator_pin_oe && !o_reset_indicator_pin_o)
    else $error("pins not floated in reset");
  chk_cpu_gate: assert property (o_sys_reset |-> !o_cpu_clk_en)
    else $error("cpu clock in reset");
  chk_pin_merge: assert property ($fell(i_reset_pin_n) |-> ##[1:4] (o_sys_reset && !o_osc_enable))
    else $error("pin reset not taken");
  chk_wdt_self: assert property ($rose(i_wdt_overflow) |-> ##[1:4] o_wdt_reset)
    else $error("watchdog not reset");
  chk_fetch_vec: assert property (o_fetch_start |-> o_fetch_vector_addr == RSC_VEC_LO_ADDR)
    else $error("wrong vector");
  chk_fetch_after: assert property (o_fetch_start |-> $past(o_pins_hiz) && !o_sys_reset)
    else $error("fetch without wait");
  chk_run_clk: assert property (o_fetch_start |-> ##[0:1] o_cpu_clk_en)
    else $error("no cpu clock after release");
  chk_masked_hold: assert property (o_halt_active && i_irq.req && i_irq.interrupt_mask_flag
    && $past(i_reset_pin_n, 2) && !$past(i_wdt_overflow, 2) && !$past(i_poc_low, 2) && !$past(i_lvd_low, 2)
    |=> o_halt_active) else $error("masked request left halt");
  chk_srv_qual: assert property (o_irq_service |-> $past(i_global_interrupt_enable)
    && !$past(i_irq.interrupt_mask_flag)
    && (!$past(i_irq.priority_level_flag) || $past(i_in_service_priority_flag))) else $error("bad service");
  cover property (o_fetch_start);
  cover property (o_irq_service);
  cover property ($fell(o_halt_active) && !o_irq_service);
endmodule : rsc_sva
bind rsc_top rsc_sva u_sva (.*);
`default_nettype wire

// >>> dv/rsc_top_bench.sv
// self-checking bench for the reset controller
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module rsc_top_bench;
  import rsc_pkg::*;
  logic i_clk = 0, i_rst, i_halt_enter, i_global_interrupt_enable, i_in_service_priority_flag, i_avs_read, i_avs_write;
  logic go, o_avs_waitrequest, o_sys_reset, o_wdt_reset, o_lvd_logic_reset, o_lvd_enable, o_poc_enable;
  logic o_osc_enable, o_ext_clk_valid, o_osc_pins_port_mode, o_cpu_clk_en, o_cpu_sel_internal_high_speed_clock;
  logic o_pins_hiz, o_reset_indicator_pin_o, o_reset_indicator_pin_oe, o_halt_active, o_irq_service, o_fetch_start;
  logic [1:0] kind;
  logic [3:0] src, i_avs_address;
  logic [15:0] o_fetch_vector_addr;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  wire logic i_reset_pin_n = !src[0], i_wdt_overflow = src[1], i_poc_low = src[2], i_lvd_low = src[3];
  rsc_irq_t i_irq;
  int n_fail = 0, check_count = 0;
  always #4 i_clk = ~i_clk;
  rsc_top #(.PROC_CYC(4), .STAB_CYC(4)) uut (.*);
  rsc_src u_src (.i_clk(i_clk), .i_go(go), .i_kind(kind), .o_src(src));
  task ok(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin n_fail++; $display("ERROR %0t %s", $time, m); end
  endtask : ok
  // one request, held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk);
    i_avs_address <= a; i_avs_writedata <= d; i_avs_write <= w; i_avs_read <= !w;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0 && t < 100) begin t++; @(posedge i_clk); end
    ok(o_avs_waitrequest === 1'b0, "bus stuck");
    q = o_avs_readdata;
    i_avs_read <= 0; i_avs_write <= 0;
    @(negedge i_clk);
  endtask : bus
  task wait_run;
    int i;
    i = 0;
    @(negedge i_clk);
    while (i < 3000 && o_fetch_start !== 1'b1) begin i++; @(negedge i_clk); end
    ok(o_fetch_start === 1'b1 && o_fetch_vector_addr === RSC_VEC_LO_ADDR, "no restart");
    ok(o_cpu_sel_internal_high_speed_clock === 1'b1, "clock select");
    @(negedge i_clk);
    ok(o_cpu_clk_en === 1'b1 && o_pins_hiz === 1'b0, "not running");
  endtask : wait_run
  task t_ind;
    bus(1, RSC_REG_CTRL, 32'h1);
    ok(o_reset_indicator_pin_oe === 1'b1 && o_reset_indicator_pin_o === 1'b1, "indicator");
    bus(0, RSC_REG_STATUS, 0);
    ok(q[4:0] === RSC_ST_RUN, "status");
    bus(0, 4'h2, 0);
    ok(q === RSC_RD_UNMAPPED, "unmapped");
  endtask : t_ind
  task t_src(input logic [1:0] k);
    @(posedge i_clk);
    kind <= k; go <= 1;
    @(posedge i_clk);
    go <= 0;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    ok(o_sys_reset === 1 && o_pins_hiz === 1 && o_reset_indicator_pin_oe === 1 && o_reset_indicator_pin_o === 0, "pins");
    ok(o_osc_enable === 0 && o_ext_clk_valid === 0 && o_osc_pins_port_mode === 1 && o_cpu_clk_en === 0, "osc");
    ok(o_poc_enable === 1 && o_lvd_enable === (k == 3) && o_lvd_logic_reset === (k != 3) && o_wdt_reset === 1, "parts");
    wait_run;
    bus(0, RSC_REG_CAUSE, 0);
    ok(q[3:0] === (4'h1 << k), "cause");
    bus(1, RSC_REG_CAUSE, 32'hf);
    bus(0, RSC_REG_CAUSE, 0);
    ok(q[3:0] === 4'h0, "cause clear");
  endtask : t_src
  task t_halt;
    logic [5:0] tb [7] = '{6'h02, 6'h0b, 6'h16, 6'h12, 6'h1f, 6'h1a, 6'h20};
    logic srv;
    for (int j = 0; j < 7; j++) begin
      if (j == 0) begin bus(1, RSC_REG_CTRL, 32'h2); @(negedge i_clk); end
      else begin @(posedge i_clk); i_halt_enter <= 1; @(posedge i_clk); i_halt_enter <= 0; @(negedge i_clk); end
      ok(o_halt_active === 1'b1, "halt entry");
      @(posedge i_clk);
      {i_irq.interrupt_mask_flag, i_irq.priority_level_flag, i_global_interrupt_enable, i_in_service_priority_flag} <= tb[j][5:2];
      i_irq.req <= 1;
      srv = 0;
      repeat (4) begin @(negedge i_clk); srv = srv | (o_irq_service === 1'b1); end
      ok(o_halt_active === !tb[j][1] && srv === tb[j][0], "halt exit");
      @(posedge i_clk);
      i_irq.req <= 0;
    end
  endtask : t_halt
  task wrap_up;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // watchdog on the whole run
  initial begin #(8 * 40000); n_fail++; wrap_up; end
  // main sequence
  initial begin
    i_rst = 1; go = 0; kind = 0; i_halt_enter = 0; i_irq = '0; i_global_interrupt_enable = 0;
    i_in_service_priority_flag = 0; i_avs_address = 0; i_avs_read = 0; i_avs_write = 0; i_avs_writedata = 0;
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    wait_run;
    t_ind;
    @(posedge i_clk);
    i_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    wait_run;
    for (int k = 0; k < 4; k++) t_src(k[1:0]);
    t_halt;
    t_src(0);
    wrap_up;
  end
endmodule : rsc_top_bench
`default_nettype wire
